//--- verilog/pin_change_map.vh
// constants for the pin change interrupt block
`ifndef PIN_CHANGE_MAP_VH
`define PIN_CHANGE_MAP_VH

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define PCD_PORT_WIDTH 8
`define PCD_MSB 7
`define PCD_RISE_EN_RESET 8'h00
`define PCD_FALL_EN_RESET 8'h00
`define PCD_FLAG_RESET 8'h00
`define PCD_GIE_RESET 1'b0
`define PCD_SYNC_RESET 8'h00

`endif

//--- verilog/pin_sync.v
// two-stage synchroniser for the port pins
`timescale 1ns/1ps
`include "pin_change_map.vh"

module pin_sync (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // asynchronous pins in, clean samples out
  input wire [`PCD_MSB:0] i_pins,
  output wire [`PCD_MSB:0] o_pins_sync
);

  reg [`PCD_MSB:0] meta_reg;
  reg [`PCD_MSB:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= `PCD_SYNC_RESET;
      sync_reg <= `PCD_SYNC_RESET;
    end else begin
      meta_reg <= i_pins;
      sync_reg <= meta_reg;
    end
  end

  assign o_pins_sync = sync_reg;

endmodule

//--- verilog/edge_detect.v
// per-pin rising and falling edge detectors
`timescale 1ns/1ps
`include "pin_change_map.vh"

module edge_detect (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // synchronised pins and enables
  input wire [`PCD_MSB:0] i_pins_sync,
  input wire [`PCD_MSB:0] i_rise_en,
  input wire [`PCD_MSB:0] i_fall_en,
  // one-cycle pulse per pin on an enabled edge
  output wire [`PCD_MSB:0] o_edge_hit
);

  reg [`PCD_MSB:0] prev_reg;
  wire [`PCD_MSB:0] rise;
  wire [`PCD_MSB:0] fall;

  // previous sample; reset to low so a pin high at reset gives one rise
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_reg <= `PCD_SYNC_RESET;
    end else begin
      prev_reg <= i_pins_sync;
    end
  end

  // compare current and previous sample every cycle
  assign rise = i_pins_sync & ~prev_reg & i_rise_en;
  assign fall = ~i_pins_sync & prev_reg & i_fall_en;
  // both enables armed gives either polarity
  assign o_edge_hit = rise | fall;

endmodule

//--- verilog/pin_change_detect.v
// pin change interrupt block for the second i/o port
`timescale 1ns/1ps
`include "pin_change_map.vh"

// Function
// - each port pin can interrupt on a rising or falling edge
// - any pin or pin combination enabled independently
// - interrupt requested only while the global enable is set
// - with global enable clear, flags still update, no interrupt
// - per-pin rising detector armed by its rise enable bit
// - per-pin falling detector armed by its fall enable bit
// - both enables set detects either polarity
// - enabled edge sets that pin's change flag
// - summary flag is the OR of all pin flags
// - writing zero to a flag bit clears it
// - edge during a clearing write leaves that flag set
// - change interrupt with global enable wakes core from sleep
// - flags updated before first instruction after wake
// - rise enable holds one bit per pin, pin 7 at bit 7
module pin_change_detect (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rstn,
  // port pins from outside
  input wire [`PCD_MSB:0] i_second_io_port,
  // global enable write
  input wire i_gie_we,
  input wire i_gie_wdata,
  // rise enable write
  input wire i_rise_we,
  input wire [`PCD_MSB:0] i_rise_wdata,
  // fall enable write
  input wire i_fall_we,
  input wire [`PCD_MSB:0] i_fall_wdata,
  // flag write: written bits replace flags, zero clears
  input wire i_flag_we,
  input wire [`PCD_MSB:0] i_flag_wdata,
  // register read-back
  output reg o_change_irq_global_enable,
  output reg [`PCD_MSB:0] o_rise_detect_enable_reg,
  output reg [`PCD_MSB:0] o_fall_detect_enable_reg,
  output reg [`PCD_MSB:0] o_change_flag_reg,
  // status and requests
  output wire o_change_irq_summary_flag,
  output wire o_irq,
  output wire o_wake
);

  // ----------------------------------------------------------
  // configuration and flags
  // ----------------------------------------------------------
  reg gie_next;
  reg [`PCD_MSB:0] rise_next;
  reg [`PCD_MSB:0] fall_next;
  reg [`PCD_MSB:0] flag_next;
  wire [`PCD_MSB:0] pins_sync;
  wire [`PCD_MSB:0] edge_hit;

  // merge software write with hardware set; set always wins
  function [`PCD_MSB:0] flag_update;
    input [`PCD_MSB:0] cur;
    input we;
    input [`PCD_MSB:0] wdata;
    input [`PCD_MSB:0] hit;
    begin
      if (we) begin
        flag_update = wdata | hit;
      end else begin
        flag_update = cur | hit;
      end
    end
  endfunction

  // ----------------------------------------------------------
  // pin path
  // ----------------------------------------------------------
  pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_pins(i_second_io_port),
    .o_pins_sync(pins_sync)
  );

  edge_detect u_edge (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_pins_sync(pins_sync),
    .i_rise_en(o_rise_detect_enable_reg),
    .i_fall_en(o_fall_detect_enable_reg),
    .o_edge_hit(edge_hit)
  );

  // next values of the software registers
  always @* begin
    gie_next = i_gie_we ? i_gie_wdata : o_change_irq_global_enable;
    rise_next = i_rise_we ? i_rise_wdata : o_rise_detect_enable_reg;
    fall_next = i_fall_we ? i_fall_wdata : o_fall_detect_enable_reg;
    // detection runs regardless of global enable
    flag_next = flag_update(o_change_flag_reg, i_flag_we, i_flag_wdata,
      edge_hit);
  end

  // all state cleared on reset
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_change_irq_global_enable <= `PCD_GIE_RESET;
      o_rise_detect_enable_reg <= `PCD_RISE_EN_RESET;
      o_fall_detect_enable_reg <= `PCD_FALL_EN_RESET;
      o_change_flag_reg <= `PCD_FLAG_RESET;
    end else begin
      o_change_irq_global_enable <= gie_next;
      o_rise_detect_enable_reg <= rise_next;
      o_fall_detect_enable_reg <= fall_next;
      o_change_flag_reg <= flag_next;
    end
  end

  // ----------------------------------------------------------
  // requests
  // ----------------------------------------------------------
  // summary and request follow the flag register, so flags are
  // already valid when the core resumes from sleep
  assign o_change_irq_summary_flag = |o_change_flag_reg;
  assign o_irq = o_change_irq_summary_flag &
    o_change_irq_global_enable;
  assign o_wake = o_irq;

endmodule

//--- tb/pin_change_detect_chk.sv
// assertions on the ports of the pin change block
`timescale 1ns/1ps
module pin_change_detect_chk (
  input wire i_ref_clk, input wire i_rstn,
  input wire [7:0] i_second_io_port,
  input wire i_gie_we, input wire i_gie_wdata,
  input wire i_rise_we, input wire [7:0] i_rise_wdata,
  input wire i_fall_we, input wire [7:0] i_fall_wdata,
  input wire i_flag_we,
  input wire o_change_irq_global_enable,
  input wire [7:0] o_rise_detect_enable_reg,
  input wire [7:0] o_fall_detect_enable_reg,
  input wire [7:0] o_change_flag_reg,
  input wire o_change_irq_summary_flag, input wire o_irq, input wire o_wake
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // a write strobe, then the edge where its result shows
  sequence wrote_s(we);
    we ##1 1'b1;
  endsequence
  // pin seen new three edges back, old four back
  rise_set_a: assert property (((($past(i_second_io_port, 3) &
    ~$past(i_second_io_port, 4)) & $past(o_rise_detect_enable_reg))
    & ~o_change_flag_reg) == 8'h00) else $error("rise edge lost");
  fall_set_a: assert property (((~$past(i_second_io_port, 3) &
    $past(i_second_io_port, 4) & $past(o_fall_detect_enable_reg))
    & ~o_change_flag_reg) == 8'h00) else $error("fall edge lost");
  flag_sticky_a: assert property (!$past(i_flag_we) |->
    (~o_change_flag_reg & $past(o_change_flag_reg)) == 8'h00)
    else $error("flag dropped without write");
  summary_or_a: assert property (o_change_irq_summary_flag ==
    (|o_change_flag_reg)) else $error("summary flag wrong");
  irq_gate_a: assert property (o_irq == ((|o_change_flag_reg) &&
    o_change_irq_global_enable)) else $error("request gating wrong");
  wake_irq_a: assert property (o_wake == o_irq)
    else $error("wake differs from request");
  rise_wr_a: assert property (wrote_s(i_rise_we) |->
    o_rise_detect_enable_reg == $past(i_rise_wdata)) else $error("rise en");
  fall_wr_a: assert property (wrote_s(i_fall_we) |->
    o_fall_detect_enable_reg == $past(i_fall_wdata)) else $error("fall en");
  gie_wr_a: assert property (wrote_s(i_gie_we) |->
    o_change_irq_global_enable == $past(i_gie_wdata)) else $error("gie");
endmodule

//--- tb/pin_source.sv
// outside signals driving the port pins
`timescale 1ns/1ps
module pin_source (
  input wire [7:0] i_level,
  output wire [7:0] o_pins
);
  // pins land off the clock edge, as unrelated outside logic would
  assign #3 o_pins = i_level;
endmodule

//--- tb/test_pin_change_detect.sv
// self-checking bench for the pin change block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module test_pin_change_detect;
  reg i_ref_clk = 0, i_rstn = 0, i_gie_we = 0, i_gie_wdata = 0, g;
  reg i_rise_we = 0, i_fall_we = 0, i_flag_we = 0;
  reg [7:0] i_rise_wdata = 0, i_fall_wdata = 0, i_flag_wdata = 0, lvl = 0;
  reg [7:0] ex = 0, old, hit, r, f, nv, m;
  reg [31:0] gv;
  wire [7:0] i_second_io_port, o_rise_detect_enable_reg;
  wire [7:0] o_fall_detect_enable_reg, o_change_flag_reg;
  wire o_change_irq_global_enable, o_change_irq_summary_flag, o_irq, o_wake;
  int errors = 0, cmp_count = 0;
  pin_change_detect pin_change_detect_i (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_second_io_port(i_second_io_port),
    .i_gie_we(i_gie_we),
    .i_gie_wdata(i_gie_wdata),
    .i_rise_we(i_rise_we),
    .i_rise_wdata(i_rise_wdata),
    .i_fall_we(i_fall_we),
    .i_fall_wdata(i_fall_wdata),
    .i_flag_we(i_flag_we),
    .i_flag_wdata(i_flag_wdata),
    .o_change_irq_global_enable(o_change_irq_global_enable),
    .o_rise_detect_enable_reg(o_rise_detect_enable_reg),
    .o_fall_detect_enable_reg(o_fall_detect_enable_reg),
    .o_change_flag_reg(o_change_flag_reg),
    .o_change_irq_summary_flag(o_change_irq_summary_flag),
    .o_irq(o_irq),
    .o_wake(o_wake)
  );
  pin_source pin_source_i (.i_level(lvl), .o_pins(i_second_io_port));
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  task summarize;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, about eight times the expected run
  initial begin
    #200000;
    errors++;
    summarize;
  end
  // ----------------------------------------
  // random pin steps with masked flag clears
  // ----------------------------------------
  initial begin
    void'($urandom(32'h0993));
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1;
    @(posedge i_ref_clk);
    #1 `CHK({o_change_irq_global_enable, o_change_flag_reg}, 9'h000)
    for (int n = 0; n < 250; n++) begin
      {r, f, nv, m} = $urandom;
      gv = $urandom;
      g = gv[3];
      old = lvl;
      // first steps: all pins toggle under rise, fall, then both
      if (n < 3) begin
        r = (n == 1) ? 8'h00 : 8'hff;
        f = (n == 0) ? 8'h00 : 8'hff;
        nv = ~old;
      end
      if (n % 5 == 0) m = 8'hff;
      @(posedge i_ref_clk);
      lvl <= nv;
      {i_rise_we, i_fall_we, i_gie_we} <= 3'b111;
      {i_rise_wdata, i_fall_wdata, i_gie_wdata} <= {r, f, g};
      @(posedge i_ref_clk);
      {i_rise_we, i_fall_we, i_gie_we} <= 3'b000;
      // clear lands on the very edge that records the new hits
      @(posedge i_ref_clk);
      i_flag_we <= m[0];
      i_flag_wdata <= ex & ~m;
      hit = (nv & ~old & r) | (~nv & old & f);
      ex = (m[0] ? ex & ~m : ex) | hit;
      @(posedge i_ref_clk);
      i_flag_we <= 0;
      #1 `CHK({o_rise_detect_enable_reg, o_fall_detect_enable_reg}, {r, f})
      `CHK(o_change_flag_reg, ex)
      `CHK({o_irq, o_wake}, {2{(|ex) & g}})
      `CHK(o_change_irq_summary_flag, |ex)
    end
    summarize;
  end
endmodule
bind pin_change_detect pin_change_detect_chk chk_i (
  .i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn),
  .i_second_io_port(i_second_io_port),
  .i_gie_we(i_gie_we),
  .i_gie_wdata(i_gie_wdata),
  .i_rise_we(i_rise_we),
  .i_rise_wdata(i_rise_wdata),
  .i_fall_we(i_fall_we),
  .i_fall_wdata(i_fall_wdata),
  .i_flag_we(i_flag_we),
  .o_change_irq_global_enable(o_change_irq_global_enable),
  .o_rise_detect_enable_reg(o_rise_detect_enable_reg),
  .o_fall_detect_enable_reg(o_fall_detect_enable_reg),
  .o_change_flag_reg(o_change_flag_reg),
  .o_change_irq_summary_flag(o_change_irq_summary_flag),
  .o_irq(o_irq),
  .o_wake(o_wake)
);
